// ==== common/radio_port_pkg.sv ====
package radio_port_pkg;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned CTRL_W        = 4;
  localparam logic [3:0]  SEL_R0        = 4'h0;
  localparam logic [3:0]  SEL_R1        = 4'h1;
  localparam logic [3:0]  SEL_R15       = 4'hf;
  localparam logic [3:0]  SEL_READBACK  = 4'h7;
  localparam int unsigned UART_BIT_POS  = 28;
  localparam int unsigned STAT_SRC_LSB  = 29;
  localparam int unsigned OSC_EN_POS    = 12;
  localparam int unsigned DIV_LSB       = 7;
  localparam int unsigned SPI_SEL_LSB   = 17;
  localparam logic [2:0]  SPI_SEL_CODE  = 3'h7;
  localparam logic [31:0] R0_RESET      = 32'h0000_0000;
  localparam logic [31:0] R1_RESET      = 32'h0000_1201;
  localparam logic [31:0] R15_RESET     = 32'h0000_000f;
  localparam logic [2:0]  SRC_REG_READY = 3'h0;
  localparam logic [2:0]  SRC_LOCK      = 3'h3;
  localparam logic [2:0]  SRC_TXRX      = 3'h6;
  localparam int unsigned RATE_DIV      = 16;
  localparam int unsigned REG_READY_US  = 10;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned REG_READY_CYC = REG_READY_US * CLK_MHZ;
  localparam logic [7:0]  APB_CTRL      = 8'h00;
  localparam logic [7:0]  APB_WORD      = 8'h04;
  localparam logic [7:0]  APB_STATUS    = 8'h08;
  localparam logic [7:0]  APB_READ      = 8'h0c;
endpackage

// ==== common/radio_port_if.sv ====
`timescale 1ns/1ps
interface radio_port_if;
  logic chip_enable;
  logic shift_clk;
  logic serial_write_in;
  logic latch_load_strobe;
  logic serial_read_out;
  logic sync_match;
  logic status_select_out;
  logic divided_ref_out;
  logic data_dev_o, data_dev_oe_n, data_host_o, data_host_oe_n;
  logic bclk_dev_o, bclk_dev_oe_n, bclk_host_o, bclk_host_oe_n;
  wire  radio_data_pin      = !data_dev_oe_n ? data_dev_o : (!data_host_oe_n ? data_host_o : 1'b1);
  wire  radio_bit_clock_pin = !bclk_dev_oe_n ? bclk_dev_o : (!bclk_host_oe_n ? bclk_host_o : 1'b1);
  modport device (input chip_enable, shift_clk, serial_write_in, latch_load_strobe,
                  radio_data_pin, radio_bit_clock_pin,
                  output serial_read_out, sync_match, status_select_out, divided_ref_out,
                  data_dev_o, data_dev_oe_n, bclk_dev_o, bclk_dev_oe_n);
  modport host (output chip_enable, shift_clk, serial_write_in, latch_load_strobe,
                data_host_o, data_host_oe_n, bclk_host_o, bclk_host_oe_n,
                input serial_read_out, sync_match, status_select_out, divided_ref_out,
                radio_data_pin, radio_bit_clock_pin);
endinterface

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // pin_sync

// ==== src/radio_port_device.sv ====
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module radio_port_device (
  input  wire logic   pclk,
  input  wire logic   presetn,
  radio_port_if.device port,
  input  wire logic   tx_mode,
  input  wire logic   pll_locked,
  input  wire logic   rx_bit,
  input  wire logic   rx_bit_valid,
  input  wire logic   sync_found,
  input  wire logic [6:0] sampler_value,
  output logic        tx_bit,
  output logic        tx_bit_valid,
  output logic [31:0] cfg_r0,
  output logic [31:0] cfg_r1
);
  logic ce, sck, sdi, le, dpin, bpin;
  pin_sync #(.W(5)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({port.chip_enable, port.shift_clk, port.serial_write_in,
                port.latch_load_strobe, port.radio_data_pin}),
    .dout    ({ce, sck, sdi, le, dpin})
  );
  assign bpin = port.radio_bit_clock_pin;
  logic bpin1_q, bpin2_q, bpin3_q, bpin_q;
  logic sck_q, le_q, bclk_q, bpin_old_q;
  logic [31:0] shift_q, r15_q, rd_q;
  logic [9:0]  ready_cnt_q;
  logic [3:0]  rate_cnt_q;
  logic [4:0]  ref_cnt_q;
  logic        ref_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Pin idles high, so no false edge out of reset
      bpin1_q <= 1'b1;
      bpin2_q <= 1'b1;
      bpin3_q <= 1'b1;
      bpin_q  <= 1'b1;
    end else begin
      bpin1_q <= bpin;
      bpin2_q <= bpin1_q;
      bpin3_q <= bpin2_q;
      if (bpin2_q == bpin3_q) begin
        bpin_q <= bpin3_q;
      end
    end
  end
  wire sck_rise = sck & ~sck_q;
  wire le_rise  = le & ~le_q;
  wire uart     = cfg_r0[radio_port_pkg::UART_BIT_POS];
  // Decoded only; no SPI-specific timing lives in this block
  wire spi_mode = uart &
                  (r15_q[radio_port_pkg::SPI_SEL_LSB +: 3] == radio_port_pkg::SPI_SEL_CODE);
  wire reg_ready = (ready_cnt_q == 10'(radio_port_pkg::REG_READY_CYC));
  // Edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      le_q  <= 1'b0;
    end else begin
      sck_q <= sck & ce;
      le_q  <= le & ce;
    end
  end
  // Shift register; readback bit moves out on each clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
      rd_q    <= '0;
    end else if (!ce) begin
      shift_q <= '0;
      rd_q    <= '0;
    end else if (sck_rise) begin
      shift_q <= {shift_q[30:0], sdi};
      rd_q    <= {rd_q[30:0], 1'b0};
    end else if (le_rise && shift_q[3:0] == radio_port_pkg::SEL_READBACK) begin
      rd_q <= {9'h000, sampler_value, 16'h0000};
    end
  end
  assign port.serial_read_out = rd_q[31];
  // Latches, loaded on strobe rise and set back to reset values while chip enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r0 <= radio_port_pkg::R0_RESET;
      cfg_r1 <= radio_port_pkg::R1_RESET;
      r15_q  <= radio_port_pkg::R15_RESET;
    end else if (!ce) begin
      cfg_r0 <= radio_port_pkg::R0_RESET;
      cfg_r1 <= radio_port_pkg::R1_RESET;
      r15_q  <= radio_port_pkg::R15_RESET;
    end else if (le_rise) begin
      unique case (shift_q[3:0])
        radio_port_pkg::SEL_R0:  cfg_r0 <= shift_q;
        radio_port_pkg::SEL_R1:  cfg_r1 <= shift_q;
        radio_port_pkg::SEL_R15: r15_q  <= shift_q;
        default: ;
      endcase
    end
  end
  // Regulator settling after enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_cnt_q <= '0;
    end else if (!ce) begin
      ready_cnt_q <= '0;
    end else if (!reg_ready) begin
      ready_cnt_q <= ready_cnt_q + 10'd1;
    end
  end
  // Status mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port.status_select_out <= 1'b0;
    end else begin
      unique case (cfg_r0[radio_port_pkg::STAT_SRC_LSB +: 3])
        radio_port_pkg::SRC_REG_READY: port.status_select_out <= reg_ready;
        radio_port_pkg::SRC_LOCK:      port.status_select_out <= pll_locked & ce;
        radio_port_pkg::SRC_TXRX:      port.status_select_out <= ~tx_mode & ce;
        default:                       port.status_select_out <= 1'b0;
      endcase
    end
  end
  // Divided reference; oscillator stops with enable or bit clear
  wire [4:0] div_n = {cfg_r1[radio_port_pkg::DIV_LSB +: 4], 1'b0};
  wire osc_on = ce & cfg_r1[radio_port_pkg::OSC_EN_POS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q <= '0;
      ref_q     <= 1'b1;
    end else if (!osc_on || div_n == 5'd0) begin
      ref_cnt_q <= '0;
      ref_q     <= 1'b1;
    end else if (ref_cnt_q >= (div_n >> 1) - 5'd1) begin
      ref_cnt_q <= '0;
      ref_q     <= ~ref_q;
    end else begin
      ref_cnt_q <= ref_cnt_q + 5'd1;
    end
  end
  assign port.divided_ref_out = ref_q;
  // Bit clock: transmit at fixed rate, receive follows rx_bit_valid one clock later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_cnt_q <= '0;
      bclk_q     <= 1'b0;
    end else if (!ce) begin
      rate_cnt_q <= '0;
      bclk_q     <= 1'b0;
    end else if (tx_mode) begin
      rate_cnt_q <= rate_cnt_q + 4'd1;
      if (rate_cnt_q == 4'(radio_port_pkg::RATE_DIV / 2 - 1) || rate_cnt_q == 4'hf) begin
        bclk_q <= ~bclk_q;
      end
    end else begin
      bclk_q <= rx_bit_valid;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit       <= 1'b0;
      tx_bit_valid <= 1'b0;
      bpin_old_q   <= 1'b1;
      port.sync_match <= 1'b0;
    end else begin
      bpin_old_q   <= bpin_q;
      tx_bit_valid <= 1'b0;
      port.sync_match <= sync_found & ce & ~tx_mode;
      if (tx_mode && !uart && rate_cnt_q == 4'hf) begin
        tx_bit       <= dpin;
        tx_bit_valid <= 1'b1;
      end else if (tx_mode && uart && bpin_q != bpin_old_q) begin
        tx_bit       <= bpin_q;
        tx_bit_valid <= 1'b1;
      end
    end
  end
  assign port.data_dev_o    = rx_bit;
  assign port.data_dev_oe_n = ~(ce & ~tx_mode);
  assign port.bclk_dev_o    = bclk_q;
  assign port.bclk_dev_oe_n = ~(ce & ~(uart & tx_mode)) | (uart & ~tx_mode);
  logic unused;
  assign unused = ^{spi_mode, r15_q[31:20], r15_q[16:0]};
endmodule // radio_port_device

// ==== src/radio_port_host.sv ====
`timescale 1ns/1ps
module radio_port_host (
  input  wire logic   pclk,
  input  wire logic   presetn,
  radio_port_if.host  port,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr
);
  logic [31:0] word_q, rd_q;
  logic [5:0]  bit_q;
  logic [2:0]  ph_q;
  logic        busy_q, ce_q, tx_q, txd_q, uart_q;
  logic        sck_q, sdo_q, le_q;
  wire acc = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // APB writes: control and word start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_q   <= 1'b0;
      tx_q   <= 1'b0;
      txd_q  <= 1'b0;
      uart_q <= 1'b0;
      word_q <= '0;
      busy_q <= 1'b0;
      bit_q  <= '0;
      ph_q   <= '0;
      sck_q  <= 1'b0;
      sdo_q  <= 1'b0;
      le_q   <= 1'b0;
      rd_q   <= '0;
    end else begin
      if (acc && pwrite && paddr == radio_port_pkg::APB_CTRL) begin
        ce_q  <= pwdata[0];
        tx_q  <= pwdata[1];
        txd_q <= pwdata[2];
        uart_q <= pwdata[3];
      end
      if (acc && pwrite && paddr == radio_port_pkg::APB_WORD && !busy_q && ce_q) begin
        word_q <= pwdata;
        busy_q <= 1'b1;
        bit_q  <= '0;
        ph_q   <= '0;
      end else if (busy_q) begin
        ph_q <= ph_q + 3'd1;
        if (bit_q < 6'd32) begin
          if (ph_q == 3'd0) begin
            sdo_q <= word_q[31 - bit_q[4:0]];
            sck_q <= 1'b0;
          end else if (ph_q == 3'd3) begin
            sck_q <= 1'b1;
            rd_q  <= {rd_q[30:0], port.serial_read_out};
          end else if (ph_q == 3'd7) begin
            bit_q <= bit_q + 6'd1;
          end
        end else begin
          sck_q <= 1'b0;
          le_q  <= (ph_q < 3'd4);
          if (ph_q == 3'd7) begin
            busy_q <= 1'b0;
          end
        end
      end
    end
  end
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      radio_port_pkg::APB_CTRL:   prdata = {28'h0, uart_q, txd_q, tx_q, ce_q};
      radio_port_pkg::APB_WORD:   prdata = word_q;
      radio_port_pkg::APB_STATUS: prdata = {28'h0, port.sync_match, port.status_select_out,
                                            port.radio_data_pin, busy_q};
      radio_port_pkg::APB_READ:   prdata = rd_q;
      default:                    prdata = 32'h0000_0000;
    endcase
  end
  assign port.chip_enable       = ce_q;
  assign port.shift_clk         = sck_q;
  assign port.serial_write_in   = sdo_q;
  assign port.latch_load_strobe = le_q;
  assign port.data_host_o       = txd_q;
  assign port.data_host_oe_n    = ~tx_q;
  assign port.bclk_host_o       = txd_q;
  // Host only drives the bit clock pin in serial-mode transmit
  assign port.bclk_host_oe_n    = ~(tx_q & uart_q);
endmodule // radio_port_host

// ==== dv/radio_port_properties.sv ====
`timescale 1ns/1ps
module radio_port_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chip_enable,
  input wire logic shift_clk,
  input wire logic serial_write_in,
  input wire logic latch_load_strobe,
  input wire logic status_select_out,
  input wire logic divided_ref_out,
  input wire logic data_dev_oe_n,
  input wire logic data_host_oe_n,
  input wire logic bclk_dev_oe_n,
  input wire logic bclk_host_oe_n
);
  localparam int READY_CYC = radio_port_pkg::REG_READY_CYC;
  logic [10:0] on_q;
  logic [5:0]  bits_q;
  logic [4:0]  idle_q;
  logic        sck_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_q <= '0;
    else if (!chip_enable) on_q <= '0;
    else if (on_q != 11'h7ff) on_q <= on_q + 11'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sck_q <= 1'b0;
    else sck_q <= shift_clk;
  end
  // Idle gap ends a count, so readback clocks never join a word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_q <= '0;
      idle_q <= '0;
    end else if (latch_load_strobe || idle_q == 5'h10) begin
      bits_q <= '0;
      idle_q <= '0;
    end else if (shift_clk && !sck_q) begin
      bits_q <= bits_q + 6'h1;
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + 5'h1;
    end
  end
  data_excl_a: assert property (data_dev_oe_n || data_host_oe_n)
    else $error("data pin driven from both ends");
  bclk_excl_a: assert property (bclk_dev_oe_n || bclk_host_oe_n)
    else $error("bit clock pin driven from both ends");
  data_hold_a: assert property (
    $rose(shift_clk) |-> $stable(serial_write_in) ##1 $stable(serial_write_in))
    else $error("write data moved at shift edge");
  strobe_width_a: assert property ($rose(latch_load_strobe) |-> latch_load_strobe[*4])
    else $error("load strobe too short");
  word_len_a: assert property ($rose(latch_load_strobe) |-> bits_q == 6'h20)
    else $error("load strobe not after 32 bits");
  off_quiet_a: assert property (!chip_enable |-> !shift_clk && !latch_load_strobe)
    else $error("serial activity while disabled");
  ready_wait_a: assert property ($rose(shift_clk) |-> on_q >= READY_CYC)
    else $error("shifting before regulator ready");
  ready_flag_a: assert property (
    $rose(status_select_out) && on_q < 11'h44c |-> on_q >= READY_CYC)
    else $error("regulator ready too early");
  osc_stop_a: assert property ((!chip_enable)[*6] |=> $stable(divided_ref_out))
    else $error("reference output runs while disabled");
  cover property ($rose(latch_load_strobe));
  cover property ($rose(status_select_out));
  cover property ($fell(chip_enable));
endmodule // radio_port_properties

// ==== dv/tb_radio_host_serial_port.sv ====
`timescale 1ns/1ps
module tb_radio_host_serial_port;
  logic        pclk, presetn, psel, penable, pwrite, pready;
  logic        tx_mode, pll_locked, sync_found;
  logic        rx_bit, rx_bit_valid, tx_bit, tx_bit_valid;
  logic [7:0]  paddr;
  logic [6:0]  sampler_value;
  logic [31:0] pwdata, prdata, st, cfg_r0, cfg_r1;
  logic [31:0] rw [4], er0 [4], er1 [4], pm [4];
  int          err_total, checked, cyc, txv, n0;
  radio_port_if bus_if ();
  radio_port_device i_radio_port_device (.pclk(pclk), .presetn(presetn), .port(bus_if),
    .tx_mode(tx_mode), .pll_locked(pll_locked), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .sync_found(sync_found), .sampler_value(sampler_value), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid),
    .cfg_r0(cfg_r0), .cfg_r1(cfg_r1));
  radio_port_host i_radio_port_host (.pclk(pclk), .presetn(presetn), .port(bus_if),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr());
  radio_port_properties prop_chk (.pclk(pclk), .presetn(presetn),
    .chip_enable(bus_if.chip_enable), .shift_clk(bus_if.shift_clk),
    .serial_write_in(bus_if.serial_write_in), .latch_load_strobe(bus_if.latch_load_strobe),
    .status_select_out(bus_if.status_select_out), .divided_ref_out(bus_if.divided_ref_out),
    .data_dev_oe_n(bus_if.data_dev_oe_n), .data_host_oe_n(bus_if.data_host_oe_n),
    .bclk_dev_oe_n(bus_if.bclk_dev_oe_n), .bclk_host_oe_n(bus_if.bclk_host_oe_n));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic results();
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  // Ends one edge late so a following call never re-drives psel in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    st = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll(input int b, input logic v);
    for (int n = 0; n < 3000; n++) begin
      apb(1'b0, radio_port_pkg::APB_STATUS, 32'h0);
      if (st[b] === v) break;
    end
    chk({31'h0, st[b]}, {31'h0, v});
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      results();
    end
  end
  // Non-blocking so reads at an edge always see the count before it
  always @(posedge pclk) txv <= txv + int'(tx_bit_valid === 1'b1);
  initial begin
    {presetn, psel, penable, pwrite, tx_mode, pll_locked, sync_found} = '0;
    {rx_bit, rx_bit_valid} = '0;
    paddr = '0;
    pwdata = '0;
    sampler_value = '0;
    rw = '{32'h0abc_de50, 32'h0000_1e11, 32'h000e_000f, 32'h1000_0000};
    er0 = '{32'h0abc_de50, 32'h0abc_de50, 32'h0abc_de50, 32'h1000_0000};
    er1 = '{radio_port_pkg::R1_RESET, 32'h0000_1e11, 32'h0000_1e11, 32'h0000_1e11};
    pm = '{32'h3, 32'h1, 32'h2, 32'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk(cfg_r0, radio_port_pkg::R0_RESET);
    chk(cfg_r1, radio_port_pkg::R1_RESET);
    chk({31'h0, bus_if.divided_ref_out}, 32'h1);
    @(posedge pclk);
    apb(1'b1, radio_port_pkg::APB_CTRL, 32'h1);
    poll(2, 1'b1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, radio_port_pkg::APB_WORD, rw[i]);
      repeat (100) @(posedge pclk);
      chk(cfg_r0, (i == 0) ? radio_port_pkg::R0_RESET : er0[i-1]);
      poll(0, 1'b0);
      chk(cfg_r0, er0[i]);
      chk(cfg_r1, er1[i]);
    end
    // Serial mode first, then back to normal mode
    for (int j = 0; j < 4; j++) begin
      if (j == 2) apb(1'b1, radio_port_pkg::APB_WORD, 32'h0);
      if (j == 2) poll(0, 1'b0);
      // Device lets go of a pin before the host takes it, never both at once
      if (j % 2 == 0) tx_mode <= 1'b1;
      apb(1'b1, radio_port_pkg::APB_CTRL, (j % 2) ? 32'h1 : ((j == 0) ? 32'hb : 32'h3));
      if (j % 2 == 1) tx_mode <= 1'b0;
      repeat (8) @(posedge pclk);
      chk({30'h0, bus_if.data_dev_oe_n, bus_if.bclk_dev_oe_n}, pm[j]);
      if (j == 0) begin
        apb(1'b1, radio_port_pkg::APB_CTRL, 32'hf);
        repeat (8) @(posedge pclk);
        chk({31'h0, tx_bit}, 32'h1);
      end
      if (j == 2) begin
        n0 = txv;
        repeat (32) @(posedge pclk);
        chk(txv - n0, 32'h2);
      end
      if (j == 3) begin
        rx_bit <= 1'b1;
        rx_bit_valid <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({30'h0, bus_if.radio_data_pin, bus_if.radio_bit_clock_pin}, 32'h3);
        rx_bit <= 1'b0;
        rx_bit_valid <= 1'b0;
      end
    end
    apb(1'b1, radio_port_pkg::APB_WORD, 32'h6000_0000);
    poll(0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      pll_locked <= (k == 0);
      sync_found <= (k == 0);
      repeat (8) @(posedge pclk);
      apb(1'b0, radio_port_pkg::APB_STATUS, 32'h0);
      chk({30'h0, st[3:2]}, (k == 0) ? 32'h3 : 32'h0);
    end
    sampler_value <= 7'h5a;
    apb(1'b1, radio_port_pkg::APB_WORD, 32'h0000_0007);
    poll(0, 1'b0);
    // Readback only leaves the device while the next word is shifted
    apb(1'b1, radio_port_pkg::APB_WORD, 32'h0000_0002);
    poll(0, 1'b0);
    apb(1'b0, radio_port_pkg::APB_READ, 32'h0);
    chk({25'h0, st[22:16]}, 32'h5a);
    apb(1'b1, radio_port_pkg::APB_CTRL, 32'h0);
    repeat (8) @(posedge pclk);
    chk(cfg_r0, radio_port_pkg::R0_RESET);
    chk(cfg_r1, radio_port_pkg::R1_RESET);
    apb(1'b1, radio_port_pkg::APB_WORD, 32'habcd_0000);
    repeat (300) @(posedge pclk);
    chk(cfg_r0, radio_port_pkg::R0_RESET);
    results();
  end
endmodule // tb_radio_host_serial_port
